/* File: hdl/itc_map.svh */
`ifndef ITC_MAP_SVH
`define ITC_MAP_SVH

// Register byte offsets
`define ITC_OFF_CTRL 12'h000
`define ITC_OFF_MINW 12'h004
`define ITC_OFF_TDLY_ACQ 12'h008
`define ITC_OFF_TDLY_FRM 12'h00c
`define ITC_OFF_STAT 12'h010
`define ITC_OFF_SWTRIG 12'h014

// Control register fields
`define ITC_CTRL_LEGACY 0
`define ITC_CTRL_MODE_LO 1
`define ITC_CTRL_MODE_HI 2
`define ITC_CTRL_SWSRC_LO 3
`define ITC_CTRL_SWSRC_HI 4
`define ITC_CTRL_STSEL 5
`define ITC_CTRL_LSEL_LO 8
`define ITC_CTRL_LSEL_HI 9

// Status register fields
`define ITC_STAT_READY 0
`define ITC_STAT_PEND_LO 1
`define ITC_STAT_PEND_HI 2

// Reset values
`define ITC_RST_CTRL 32'h0000_0020
`define ITC_RST_MINW 7'h00
`define ITC_RST_TDLY 24'h00_0000

// Field widths
`define ITC_MINW_W 7
`define ITC_TDLY_W 24
`define ITC_MINC_W 14
`define ITC_DLYC_W 31

// Timing
`define ITC_CLK_PERIOD_NS 8
`define ITC_NS_PER_US 1000
`define ITC_CYC_PER_US \
  ((`ITC_NS_PER_US + `ITC_CLK_PERIOD_NS - 1) / `ITC_CLK_PERIOD_NS)
`define ITC_MINW_MAX_US 100
`define ITC_TDLY_MAX_US 10000000

`endif

/* File: hdl/itc_pkg.sv */
package itc_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } itc_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } itc_apb_rsp_s;

  typedef enum logic {
    ITC_DLY_IDLE,
    ITC_DLY_RUN
  } itc_dly_e;

endpackage

/* File: hdl/itc_stretch.sv */
`timescale 1ns/100ps
`include "itc_map.svh"

module itc_stretch #(
  parameter int CW = `ITC_MINC_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic src,
  input wire logic [CW-1:0] min_cyc,
  output logic line
);
  logic src_d_r;
  logic [CW-1:0] cnt_r;
  logic line_r;
  logic rise;

  assign rise = src & ~src_d_r;
  assign line = line_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_d_r <= 1'b0;
    end else begin
      src_d_r <= src;
    end
  end

  // A rise loads the hold count; the line stays high while the source
  // does or the count runs, so the wider of the two wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (rise && min_cyc != '0) begin
      cnt_r <= min_cyc - CW'(1); // R1
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_r <= 1'b0;
    end else begin
      line_r <= src | (cnt_r != '0); // R2
    end
  end
endmodule // itc_stretch

/* File: hdl/itc_top.sv */
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
`include "itc_map.svh"

// How it works
// R1: A line pulse shorter than its minimum width is held out to exactly that width.
// R2: A line pulse at least as wide as its minimum leaves unchanged in width.
// R3: Each minimum width is set in microseconds from 0 to 100.
// R4: Four lines each keep their own minimum, chosen for access by a selector.
// R5: A hardware trigger waits a programmed 0 to 10000000 us before acting.
// R6: A delay of zero lets a hardware trigger act at once.
// R7: Standard mode delays both triggers; legacy mode only acquisition start.
// R8: No delay acts on a trigger whose mode is off or that comes from software.
// R9: The ready flag, when selected, shows readiness for the mode's trigger.
// R10: Acquisition start has no readable status of its own.
// R11: Software should poll the ready flag before each software trigger.
// R12: Microsecond settings become clock counts rounded up, never shorter.
module itc_top #(
  parameter int NUM_OUT = 4,
  parameter int MINW_MAX_US = `ITC_MINW_MAX_US,
  parameter int TDLY_MAX_US = `ITC_TDLY_MAX_US
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire itc_pkg::itc_apb_req_s apb_req,
  output itc_pkg::itc_apb_rsp_s apb_rsp,
  input wire logic hw_acq_trig_pin,
  input wire logic hw_frm_trig_pin,
  input wire logic [NUM_OUT-1:0] out_src,
  input wire logic acq_ready_in,
  input wire logic frm_ready_in,
  output logic [NUM_OUT-1:0] out_line,
  output logic acq_start_eff,
  output logic frm_start_eff
);
  import itc_pkg::*;

  localparam int LSW = 2;
  localparam int NCH = 2;
  localparam logic [`ITC_MINW_W-1:0] MINW_MAX =
    `ITC_MINW_W'(MINW_MAX_US);
  localparam logic [`ITC_TDLY_W-1:0] TDLY_MAX =
    `ITC_TDLY_W'(TDLY_MAX_US);
  localparam logic [7:0] CYC_US = 8'(`ITC_CYC_PER_US);
  // A literal cannot be bit-selected, so the reset word gets a name
  localparam logic [31:0] RST_CTRL = `ITC_RST_CTRL;

  if (NUM_OUT < 1 || NUM_OUT > 4) begin : g_chk_out
    $error("itc_top: NUM_OUT must be 1 to 4");
  end
  if (MINW_MAX_US < 0 || MINW_MAX_US > 127) begin : g_chk_minw
    $error("itc_top: MINW_MAX_US out of range");
  end
  if (TDLY_MAX_US < 0 || TDLY_MAX_US > 16777215) begin : g_chk_tdly
    $error("itc_top: TDLY_MAX_US out of range");
  end

  // Control state
  logic legacy_r;
  logic [NCH-1:0] mode_on_r;
  logic [NCH-1:0] sw_src_r;
  logic stsel_r;
  logic [LSW-1:0] lsel_r;
  logic [`ITC_MINW_W-1:0] minw_r [NUM_OUT];
  logic [`ITC_TDLY_W-1:0] tdly_r [NCH];

  // Bus state
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic addr_ok;
  logic setup;
  logic wr_commit;
  logic [11:0] addr;
  logic [31:0] wdata;

  // Trigger path state
  logic [NCH-1:0] pin_in;
  logic [NCH-1:0] sync1_r;
  logic [NCH-1:0] sync2_r;
  logic [NCH-1:0] prev_r;
  logic [NCH-1:0] hw_edge;
  logic [NCH-1:0] hw_take;
  logic [NCH-1:0] sw_pulse;
  logic [NCH-1:0] dly_apply;
  logic [NCH-1:0] fire;
  logic [NCH-1:0] eff_r;
  logic [NCH-1:0] pend;
  logic ready_r;

  logic [`ITC_MINW_W-1:0] minw_wr;
  logic [`ITC_TDLY_W-1:0] tdly_wr;

  assign addr = apb_req.paddr;
  assign wdata = apb_req.pwdata;
  assign setup = apb_req.psel & ~apb_req.penable;
  assign wr_commit = apb_req.psel & apb_req.penable & pready_r &
                     apb_req.pwrite;
  assign pin_in = {hw_frm_trig_pin, hw_acq_trig_pin};

  assign apb_rsp.prdata = prdata_r;
  assign apb_rsp.pready = pready_r;
  assign apb_rsp.pslverr = pslverr_r;
  assign acq_start_eff = eff_r[0];
  assign frm_start_eff = eff_r[1];

  // Out-of-range writes saturate instead of wrapping
  assign minw_wr = (wdata[31:`ITC_MINW_W] != '0 ||
                    wdata[`ITC_MINW_W-1:0] > MINW_MAX) ?
                   MINW_MAX : wdata[`ITC_MINW_W-1:0]; // R3
  assign tdly_wr = (wdata[31:`ITC_TDLY_W] != '0 ||
                    wdata[`ITC_TDLY_W-1:0] > TDLY_MAX) ?
                   TDLY_MAX : wdata[`ITC_TDLY_W-1:0]; // R5

  always_comb begin
    unique case (addr)
      `ITC_OFF_CTRL, `ITC_OFF_MINW, `ITC_OFF_TDLY_ACQ,
      `ITC_OFF_TDLY_FRM, `ITC_OFF_STAT, `ITC_OFF_SWTRIG: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle so it stands all access phase
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    unique case (addr)
      `ITC_OFF_CTRL: begin
        prdata_nxt[`ITC_CTRL_LEGACY] = legacy_r;
        prdata_nxt[`ITC_CTRL_MODE_HI:`ITC_CTRL_MODE_LO] = mode_on_r;
        prdata_nxt[`ITC_CTRL_SWSRC_HI:`ITC_CTRL_SWSRC_LO] = sw_src_r;
        prdata_nxt[`ITC_CTRL_STSEL] = stsel_r;
        prdata_nxt[`ITC_CTRL_LSEL_HI:`ITC_CTRL_LSEL_LO] = lsel_r;
      end
      `ITC_OFF_MINW: begin
        if (32'(lsel_r) < NUM_OUT) begin
          prdata_nxt[`ITC_MINW_W-1:0] = minw_r[lsel_r]; // R4
        end
      end
      `ITC_OFF_TDLY_ACQ: prdata_nxt[`ITC_TDLY_W-1:0] = tdly_r[0];
      `ITC_OFF_TDLY_FRM: prdata_nxt[`ITC_TDLY_W-1:0] = tdly_r[1];
      `ITC_OFF_STAT: begin
        // Only the trigger-wait status exists; the start command has none
        prdata_nxt[`ITC_STAT_READY] = ready_r; // R10
        prdata_nxt[`ITC_STAT_PEND_HI:`ITC_STAT_PEND_LO] = pend;
      end
      default: prdata_nxt = 32'h0000_0000;
    endcase
  end

  // Zero-wait slave: ready rises for the access phase after every setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & ~addr_ok;
      if (setup) begin
        prdata_r <= (apb_req.pwrite || !addr_ok) ? 32'h0000_0000 :
                    prdata_nxt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      legacy_r <= RST_CTRL[`ITC_CTRL_LEGACY];
      mode_on_r <= RST_CTRL[`ITC_CTRL_MODE_HI:`ITC_CTRL_MODE_LO];
      sw_src_r <= RST_CTRL[`ITC_CTRL_SWSRC_HI:`ITC_CTRL_SWSRC_LO];
      stsel_r <= RST_CTRL[`ITC_CTRL_STSEL];
      lsel_r <= RST_CTRL[`ITC_CTRL_LSEL_HI:`ITC_CTRL_LSEL_LO];
    end else if (wr_commit && addr == `ITC_OFF_CTRL) begin
      legacy_r <= wdata[`ITC_CTRL_LEGACY];
      mode_on_r <= wdata[`ITC_CTRL_MODE_HI:`ITC_CTRL_MODE_LO];
      sw_src_r <= wdata[`ITC_CTRL_SWSRC_HI:`ITC_CTRL_SWSRC_LO];
      stsel_r <= wdata[`ITC_CTRL_STSEL];
      lsel_r <= wdata[`ITC_CTRL_LSEL_HI:`ITC_CTRL_LSEL_LO];
    end
  end

  // A write lands only in the line the selector points at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        minw_r[i] <= `ITC_RST_MINW;
      end
    end else if (wr_commit && addr == `ITC_OFF_MINW) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        if (32'(lsel_r) == i) begin
          minw_r[i] <= minw_wr; // R4
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdly_r[0] <= `ITC_RST_TDLY;
      tdly_r[1] <= `ITC_RST_TDLY;
    end else if (wr_commit) begin
      if (addr == `ITC_OFF_TDLY_ACQ) begin
        tdly_r[0] <= tdly_wr;
      end
      if (addr == `ITC_OFF_TDLY_FRM) begin
        tdly_r[1] <= tdly_wr;
      end
    end
  end

  // Software trigger strobes, one cycle, only for a software-sourced
  // trigger whose mode is on
  assign sw_pulse = (wr_commit && addr == `ITC_OFF_SWTRIG) ?
                    (wdata[NCH-1:0] & mode_on_r & sw_src_r) : '0;

  // Trigger pins come from outside the clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign hw_edge = sync2_r & ~prev_r;
  assign hw_take = hw_edge & mode_on_r & ~sw_src_r; // R8
  // Frame start is delayed only in standard mode
  assign dly_apply = {~legacy_r, 1'b1}; // R7

  for (genvar c = 0; c < NCH; c++) begin : g_dly
    itc_dly_e st_r;
    logic [`ITC_DLYC_W-1:0] cnt_r;
    logic [`ITC_DLYC_W-1:0] dly_cyc;
    logic direct;

    // Whole microseconds times whole cycles per microsecond, rounded up
    // Operands widened first so the full product is kept
    assign dly_cyc = `ITC_DLYC_W'(tdly_r[c]) *
                     `ITC_DLYC_W'(CYC_US); // R12
    // A new edge while one is pending is dropped, not queued
    assign direct = hw_take[c] &
                    (~dly_apply[c] | (tdly_r[c] == '0)); // R6

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        st_r <= ITC_DLY_IDLE;
        cnt_r <= '0;
      end else begin
        unique case (st_r)
          ITC_DLY_IDLE: begin
            if (hw_take[c] && dly_apply[c] && tdly_r[c] != '0) begin
              st_r <= ITC_DLY_RUN; // R5
              cnt_r <= dly_cyc;
            end
          end
          ITC_DLY_RUN: begin
            if (cnt_r == `ITC_DLYC_W'(1)) begin
              st_r <= ITC_DLY_IDLE;
            end
            cnt_r <= cnt_r - `ITC_DLYC_W'(1);
          end
        endcase
      end
    end

    assign fire[c] = (st_r == ITC_DLY_RUN) &&
                     (cnt_r == `ITC_DLYC_W'(1)); // R5
    assign pend[c] = (st_r == ITC_DLY_RUN);

    // Software triggers bypass the delay entirely
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        eff_r[c] <= 1'b0;
      end else begin
        eff_r[c] <= fire[c] | direct | sw_pulse[c]; // R8
      end
    end
  end

  // Ready flag follows the trigger that this mode waits on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= stsel_r &
                 (legacy_r ? acq_ready_in : frm_ready_in); // R9
    end
  end

  // Output line conditioning
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    logic [`ITC_MINC_W-1:0] min_cyc;

    assign min_cyc = `ITC_MINC_W'(minw_r[i]) *
                     `ITC_MINC_W'(CYC_US); // R12

    itc_stretch #(
      .CW(`ITC_MINC_W)
    ) u_stretch (
      .pclk(pclk),
      .presetn(presetn),
      .src(out_src[i]),
      .min_cyc(min_cyc),
      .line(out_line[i])
    );
  end
endmodule // itc_top

/* File: tb/itc_trig_src.sv */
`timescale 1ns/100ps
module itc_trig_src (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] fire,
  output logic [1:0] pin
);
  logic [2:0] a_r;
  logic [2:0] f_r;
  // Three cycles high so the two-flop sync always sees the edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_r <= '0;
      f_r <= '0;
    end else begin
      a_r <= fire[0] ? 3'h7 : a_r >> 1;
      f_r <= fire[1] ? 3'h7 : f_r >> 1;
    end
  end
  assign pin = {f_r[0], a_r[0]};
endmodule // itc_trig_src

/* File: tb/itc_chk.sv */
`timescale 1ns/100ps
module itc_chk #(
  parameter int NUM_OUT = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire itc_pkg::itc_apb_req_s apb_req,
  input wire itc_pkg::itc_apb_rsp_s apb_rsp,
  input wire logic [NUM_OUT-1:0] out_src,
  input wire logic [NUM_OUT-1:0] out_line,
  input wire logic acq_start_eff,
  input wire logic frm_start_eff
);
  import itc_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_acc;
    apb_req.psel && apb_req.penable && apb_rsp.pready;
  endsequence
  property p_answer;
    s_setup |=> s_acc;
  endproperty
  property p_pulse;
    apb_rsp.pready |=> !apb_rsp.pready;
  endproperty
  property p_err;
    apb_rsp.pslverr |-> apb_rsp.pready;
  endproperty
  property p_rise;
    $rose(out_line[0]) |-> $past(out_src[0]);
  endproperty
  property p_fall;
    $fell(out_line[0]) |-> !$past(out_src[0]);
  endproperty
  property p_pass;
    out_src[1] |=> out_line[1];
  endproperty
  property p_acq;
    acq_start_eff |=> !acq_start_eff;
  endproperty
  property p_frm;
    frm_start_eff |=> !frm_start_eff;
  endproperty
  a_answer: assert property (p_answer) else $error("No zero-wait answer");
  a_pulse: assert property (p_pulse) else $error("Ready too long");
  a_err: assert property (p_err) else $error("Error without ready");
  a_rise: assert property (p_rise) else $error("Line rose alone");
  a_fall: assert property (p_fall) else $error("Line cut short");
  a_pass: assert property (p_pass) else $error("Line not passed");
  a_acq: assert property (p_acq) else $error("Acq start too long");
  a_frm: assert property (p_frm) else $error("Frame start too long");
endmodule // itc_chk
bind itc_top itc_chk #(.NUM_OUT(NUM_OUT)) i_itc_chk (
  .pclk(pclk),
  .presetn(presetn),
  .apb_req(apb_req),
  .apb_rsp(apb_rsp),
  .out_src(out_src),
  .out_line(out_line),
  .acq_start_eff(acq_start_eff),
  .frm_start_eff(frm_start_eff)
);

/* File: tb/itc_top_tb.sv */
`timescale 1ns/100ps
`include "itc_map.svh"
module itc_top_tb;
  import itc_pkg::*;
  logic pclk, presetn, acq_rdy, frm_rdy, acq, frm, rerr;
  logic [1:0] fire, pins;
  logic [3:0] src, line;
  logic [31:0] rdat;
  itc_apb_req_s req;
  itc_apb_rsp_s rsp;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  itc_top #(.NUM_OUT(4)) i_itc_top (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .hw_acq_trig_pin(pins[0]), .hw_frm_trig_pin(pins[1]),
    .out_src(src), .acq_ready_in(acq_rdy), .frm_ready_in(frm_rdy),
    .out_line(line), .acq_start_eff(acq), .frm_start_eff(frm));
  itc_trig_src i_itc_trig_src (
    .pclk(pclk), .presetn(presetn), .fire(fire), .pin(pins));
  always #4 pclk = ~pclk;
  task report_and_stop;
    $display("Counts: compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Ceiling well above the longest delay scenario
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Waits for the answer at rising edges; only the ceiling ends a hang
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req <= '0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    cmp(rdat, e);
    cmp({31'h0, rerr}, {31'h0, ee});
  endtask
  // Counts line cycles high after a src pulse of len cycles
  task lw(input int i, input int len, input int e);
    int n;
    n = 0;
    @(posedge pclk);
    src[i] <= 1'b1;
    for (int k = 0; k < 20000; k++) begin
      @(negedge pclk);
      if (line[i] === 1'b1) n++;
      else if (n > 0) break;
      @(posedge pclk);
      if (k == len - 1) src[i] <= 1'b0;
    end
    cmp(n, e);
  endtask
  // Edges from fire to effective start; 0 means none seen
  task tg(input logic [1:0] f, input int e);
    int n;
    @(posedge pclk);
    fire <= f;
    for (n = 1; n < 1500; n++) begin
      @(posedge pclk);
      if (n == 1) fire <= 2'h0;
      @(negedge pclk);
      if ((f[0] ? acq : frm) === 1'b1) break;
    end
    cmp(n == 1500 ? 0 : n, e);
  endtask
  task sw(input logic [1:0] b, input logic [1:0] e);
    wr(`ITC_OFF_SWTRIG, {30'h0, b});
    @(negedge pclk);
    cmp({frm, acq}, e);
  endtask
  task rdy(input logic [31:0] c, input logic a, f, e);
    wr(`ITC_OFF_CTRL, c);
    @(posedge pclk);
    acq_rdy <= a;
    frm_rdy <= f;
    rd(`ITC_OFF_STAT, {31'h0, e}, 1'b0);
  endtask
  initial begin
    pclk = 0;
    presetn = 0;
    req = '0;
    fire = '0;
    src = '0;
    acq_rdy = 0;
    frm_rdy = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ITC_OFF_CTRL, 32'h20, 1'b0);
    rd(`ITC_OFF_MINW, 32'h0, 1'b0);
    rd(`ITC_OFF_TDLY_ACQ, 32'h0, 1'b0);
    rd(12'h018, 32'h0, 1'b1);
    wr(`ITC_OFF_STAT, 32'h7);
    rd(`ITC_OFF_STAT, 32'h0, 1'b0);
    $display("Test registers done");
    wr(`ITC_OFF_MINW, 32'h1);
    wr(`ITC_OFF_CTRL, 32'h220);
    wr(`ITC_OFF_MINW, 32'd200);
    rd(`ITC_OFF_MINW, 32'd100, 1'b0);
    wr(`ITC_OFF_CTRL, 32'h120);
    wr(`ITC_OFF_MINW, 32'h0);
    wr(`ITC_OFF_CTRL, 32'h20);
    rd(`ITC_OFF_MINW, 32'h1, 1'b0);
    lw(0, 1, 125);
    lw(0, 200, 200);
    lw(1, 1, 1);
    lw(2, 1, 12500);
    lw(3, 1, 1);
    $display("Test lines done");
    wr(`ITC_OFF_TDLY_ACQ, 32'h2);
    wr(`ITC_OFF_CTRL, 32'h26);
    tg(2'h1, 254);
    tg(2'h2, 4);
    wr(`ITC_OFF_TDLY_FRM, 32'h1);
    tg(2'h2, 129);
    wr(`ITC_OFF_CTRL, 32'h27);
    tg(2'h2, 4);
    tg(2'h1, 254);
    wr(`ITC_OFF_CTRL, 32'h20);
    tg(2'h1, 0);
    tg(2'h2, 0);
    wr(`ITC_OFF_CTRL, 32'h3e);
    tg(2'h1, 0);
    rdy(32'h3e, 1'b1, 1'b1, 1'b1);
    sw(2'h3, 2'h3);
    wr(`ITC_OFF_CTRL, 32'h26);
    sw(2'h3, 2'h0);
    rd(`ITC_OFF_SWTRIG, 32'h0, 1'b0);
    $display("Test triggers done");
    rdy(32'h26, 1'b0, 1'b1, 1'b1);
    rdy(32'h27, 1'b0, 1'b1, 1'b0);
    rdy(32'h27, 1'b1, 1'b0, 1'b1);
    rdy(32'h07, 1'b1, 1'b1, 1'b0);
    $display("Test ready done");
    report_and_stop();
  end
endmodule // itc_top_tb
